// *** hdl/analog_input_event_trigger.sv ***
// Analog input event trigger: formats conversion results, decides per channel
// when a process-data word is released, and serializes it low byte first.
// Assumes results arrive on clk_in and the object port comes from the same clock.
// Operation
// R1: Result placed as sign bit 15, result bits 14..5, zero bits 4..0.
// R2: Each analog word goes out low byte first, then high byte.
// R3: Per-channel select byte: bit0 upper, bit1 lower, bit2 delta; rest unused.
// R4: Every select byte resets to delta-only.
// R5: With global enable set, a fired trigger releases the analog process-data word.
// R6: Source bitmap bit set to one for each channel that caused a trigger.
// R7: Source bitmap clears when read by the master or sent in process data; a sent word clears only its own channel's bit.
// R8: Global enable resets to zero; master must write one before triggers act.
// R9: Limit trigger fires when value is above upper or below lower limit.
// R10: Pure limit trigger resends the value on every evaluation while it holds.
// R11: Limits compared as left-aligned 32-bit values, both resetting to zero.
// R12: Upper plus delta selected sends only when beyond limit and changed enough.
// R13: Delta trigger sends only when change from last sent exceeds the delta.
// R14: Delta resets to the left-aligned encoding of five conversion steps.
// R15: Both limits selected and value inside band sends nothing.
// R16: Last sent value updated each time a channel's word is sent.
// R17: Eight channels, each with select byte, limit pair and delta.
`timescale 1ns/1ps

module analog_input_event_trigger
    import analog_trigger_pkg::*;
(
    input  wire logic                sample_valid_in,
    input  wire logic [CHAN_W-1:0]   sample_chan_in,
    input  wire logic [RESULT_W-1:0] sample_result_in,
    input  wire logic                sample_sign_in,
    output logic                     sample_ready_out,
    input  wire logic                sdo_write_in,
    input  wire logic                sdo_read_in,
    input  wire logic [15:0]         sdo_index_in,
    input  wire logic [7:0]          sdo_subindex_in,
    input  wire logic [31:0]         sdo_wdata_in,
    output logic      [31:0]         sdo_rdata_out,
    output logic                     sdo_done_out,
    output logic                     sdo_error_out,
    output logic                     pdo_valid_out,
    output logic      [7:0]          pdo_byte_out,
    output logic      [CHAN_W-1:0]   pdo_channel_out,
    output logic                     pdo_last_out,
    input  wire logic                pdo_ready_in,
    input  wire logic                clk_in,
    input  wire logic                rst_b_in
);

    logic [7:0]         sel_r   [CHANNELS]; // R17
    logic [LIMIT_W-1:0] upper_r [CHANNELS];
    logic [LIMIT_W-1:0] lower_r [CHANNELS];
    logic [DELTA_W-1:0] delta_r [CHANNELS];
    logic [WORD_W-1:0]  last_r  [CHANNELS];
    logic [7:0]         enable_r;
    logic [7:0]         flags_r;
    logic [7:0]         flags_nxt;

    logic [WORD_W-1:0]  word;
    logic [LIMIT_W-1:0] word32;
    logic [7:0]         sel;
    logic               above;
    logic               below;
    logic               changed;
    logic               lim_sel;
    logic               fire;
    logic               accept;
    logic               push;
    logic [WORD_W:0]    diff;
    logic [WORD_W:0]    mag;

    logic [ENTRY_W-1:0] buf_data;
    logic               buf_valid;
    logic               buf_take;
    ser_state_t         state_r;
    logic [WORD_W-1:0]  cur_word_r;
    logic               sent_pulse;

    logic               obj_hit;
    logic               chan_sub;
    logic [CHAN_W-1:0]  sub_chan;
    logic               wr_ok;
    logic               rd_ok;
    logic [31:0]        rd_value;
    logic               flags_read;

    ////////////////////////////////////////////////////////////////////////////
    // Formatting and trigger evaluation
    assign word   = {sample_sign_in, sample_result_in, {PAD_W{1'b0}}}; // R1
    assign word32 = {word, 16'h0000}; // R11
    assign sel    = sel_r[sample_chan_in];

    assign above   = sel[SEL_UPPER_BIT] && ($signed(word32) > $signed(upper_r[sample_chan_in])); // R9
    assign below   = sel[SEL_LOWER_BIT] && ($signed(word32) < $signed(lower_r[sample_chan_in])); // R9
    assign diff    = $signed({word[WORD_W-1], word})
                   - $signed({last_r[sample_chan_in][WORD_W-1], last_r[sample_chan_in]});
    assign mag     = diff[WORD_W] ? (~diff + 17'h0_0001) : diff;
    assign changed = mag > {1'b0, delta_r[sample_chan_in]}; // R13
    assign lim_sel = sel[SEL_UPPER_BIT] || sel[SEL_LOWER_BIT];

    // Inside the band neither limit term is true, so nothing fires
    assign fire = enable_r[ENABLE_BIT] // R5 R8
               && (lim_sel || sel[SEL_DELTA_BIT])
               && (!lim_sel || above || below) // R10 R15
               && (!sel[SEL_DELTA_BIT] || changed); // R12 R13

    // A stalled buffer holds off the converter rather than dropping a word
    assign accept = sample_valid_in && sample_ready_out;
    assign push   = accept && fire;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            for (int i = 0; i < CHANNELS; i++)
                last_r[i] <= LAST_RESET;
        end
        else if (push)
        begin
            last_r[sample_chan_in] <= word; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source bitmap: set wins over read or send clear
    // A read beaten by a write returns nothing, so it must not clear either
    assign flags_read = sdo_read_in && !sdo_write_in && (sdo_index_in == IDX_SOURCE_FLAGS)
                     && (sdo_subindex_in == SUB_FLAGS);

    always_comb
    begin
        flags_nxt = flags_r;
        if (flags_read)
            flags_nxt = FLAGS_RESET; // R7
        if (sent_pulse)
            flags_nxt[pdo_channel_out] = 1'b0; // R7
        if (push)
            flags_nxt[sample_chan_in] = 1'b1; // R6
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            flags_r <= FLAGS_RESET;
        else
            flags_r <= flags_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer and byte serializer
    pdo_word_buffer u_buffer (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (push),
        .in_data_in    ({sample_chan_in, word}),
        .in_ready_out  (sample_ready_out),
        .out_valid_out (buf_valid),
        .out_data_out  (buf_data),
        .out_ready_in  (buf_take)
    );

    assign buf_take   = (state_r == SER_IDLE);
    assign sent_pulse = (state_r == SER_HIGH) && pdo_ready_in;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_r         <= SER_IDLE;
            cur_word_r      <= 16'h0000;
            pdo_valid_out   <= 1'b0;
            pdo_byte_out    <= 8'h00;
            pdo_channel_out <= 3'h0;
            pdo_last_out    <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                SER_IDLE:
                begin
                    if (buf_valid)
                    begin
                        cur_word_r      <= buf_data[WORD_W-1:0];
                        pdo_channel_out <= buf_data[ENTRY_W-1:WORD_W];
                        pdo_byte_out    <= buf_data[7:0]; // R2
                        pdo_valid_out   <= 1'b1;
                        pdo_last_out    <= 1'b0;
                        state_r         <= SER_LOW;
                    end
                end
                SER_LOW:
                begin
                    if (pdo_ready_in)
                    begin
                        pdo_byte_out <= cur_word_r[15:8]; // R2
                        pdo_last_out <= 1'b1;
                        state_r      <= SER_HIGH;
                    end
                end
                SER_HIGH:
                begin
                    if (pdo_ready_in)
                    begin
                        pdo_valid_out <= 1'b0;
                        pdo_last_out  <= 1'b0;
                        state_r       <= SER_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Object access port
    assign sub_chan = sdo_subindex_in[CHAN_W-1:0] - 3'h1;
    assign chan_sub = (sdo_subindex_in >= SUB_FIRST) && (sdo_subindex_in <= SUB_LAST);
    assign obj_hit  = (sdo_index_in == IDX_TRIGGER_SELECT) || (sdo_index_in == IDX_UPPER_THRESHOLD)
                   || (sdo_index_in == IDX_LOWER_THRESHOLD) || (sdo_index_in == IDX_CHANGE_THRESH);
    assign wr_ok    = (obj_hit && chan_sub)
                   || ((sdo_index_in == IDX_GLOBAL_ENABLE) && (sdo_subindex_in == SUB_GLOBAL));
    assign rd_ok    = wr_ok || (obj_hit && (sdo_subindex_in == SUB_COUNT)) || flags_read;

    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (obj_hit && (sdo_subindex_in == SUB_COUNT))
            rd_value = {24'h00_0000, SUB_LAST};
        else if (sdo_index_in == IDX_TRIGGER_SELECT)
            rd_value = {24'h00_0000, sel_r[sub_chan]};
        else if (sdo_index_in == IDX_UPPER_THRESHOLD)
            rd_value = upper_r[sub_chan];
        else if (sdo_index_in == IDX_LOWER_THRESHOLD)
            rd_value = lower_r[sub_chan];
        else if (sdo_index_in == IDX_CHANGE_THRESH)
            rd_value = {16'h0000, delta_r[sub_chan]};
        else if (sdo_index_in == IDX_GLOBAL_ENABLE)
            rd_value = {24'h00_0000, enable_r};
        else if (sdo_index_in == IDX_SOURCE_FLAGS)
            rd_value = {24'h00_0000, flags_r};
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                sel_r[i]   <= SEL_RESET; // R4
                upper_r[i] <= LIMIT_RESET; // R11
                lower_r[i] <= LIMIT_RESET; // R11
                delta_r[i] <= DELTA_RESET; // R14
            end
            enable_r <= ENABLE_RESET; // R8
        end
        else if (sdo_write_in && wr_ok)
        begin
            unique case (sdo_index_in)
                IDX_TRIGGER_SELECT:  sel_r[sub_chan]   <= sdo_wdata_in[7:0] & SEL_MASK; // R3
                IDX_UPPER_THRESHOLD: upper_r[sub_chan] <= sdo_wdata_in;
                IDX_LOWER_THRESHOLD: lower_r[sub_chan] <= sdo_wdata_in;
                IDX_CHANGE_THRESH:   delta_r[sub_chan] <= sdo_wdata_in[DELTA_W-1:0];
                IDX_GLOBAL_ENABLE:   enable_r          <= sdo_wdata_in[7:0];
                default:             enable_r          <= enable_r;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sdo_rdata_out <= 32'h0000_0000;
            sdo_done_out  <= 1'b0;
            sdo_error_out <= 1'b0;
        end
        else
        begin
            sdo_done_out  <= sdo_write_in || sdo_read_in;
            // Write takes precedence when both strobes arrive together
            sdo_error_out <= sdo_write_in ? !wr_ok : (sdo_read_in && !rd_ok);
            if (sdo_read_in && !sdo_write_in)
                sdo_rdata_out <= rd_ok ? rd_value : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic first_r;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            first_r <= 1'b1;
        else
            first_r <= 1'b0;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_format;
        push |-> (word[4:0] == 5'h00) && (word[14:5] == sample_result_in)
              && (word[15] == sample_sign_in);
    endproperty
    a_format: assert property (p_format) else $error("word layout wrong"); // R1

    property p_byte_order;
        (pdo_valid_out && pdo_ready_in && !pdo_last_out)
            |=> pdo_valid_out && pdo_last_out && (pdo_byte_out == $past(cur_word_r[15:8]));
    endproperty
    a_byte_order: assert property (p_byte_order) else $error("high byte not second"); // R2

    property p_reset_defaults;
        first_r |-> (sel_r[0] == SEL_RESET) && (delta_r[7] == DELTA_RESET)
                 && (upper_r[3] == LIMIT_RESET) && (enable_r == ENABLE_RESET);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset value"); // R4

    property p_reserved;
        (sel_r[1][7:3] == 5'h00) && (sel_r[6][7:3] == 5'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved select bits set"); // R3

    property p_enable_gate;
        push |-> enable_r[ENABLE_BIT];
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("push while disabled"); // R8

    property p_flag_set;
        push |=> flags_r[$past(sample_chan_in)];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("source flag not set"); // R6

    property p_flag_read_clear;
        (flags_read && !push && !sent_pulse) |=> (flags_r == FLAGS_RESET);
    endproperty
    a_flag_read_clear: assert property (p_flag_read_clear) else $error("flags not cleared"); // R7

    property p_upper_only;
        (accept && enable_r[ENABLE_BIT] && (sel == 8'h01) && above) |-> push;
    endproperty
    a_upper_only: assert property (p_upper_only) else $error("limit send missed"); // R10

    property p_band;
        (accept && (sel == 8'h03) && !above && !below) |-> !push;
    endproperty
    a_band: assert property (p_band) else $error("sent inside band"); // R15

    property p_upper_delta;
        (accept && (sel == 8'h05) && !(above && changed)) |-> !push;
    endproperty
    a_upper_delta: assert property (p_upper_delta) else $error("upper plus delta misfire"); // R12

    property p_delta;
        (accept && enable_r[ENABLE_BIT] && (sel == SEL_RESET)) |-> (push == changed);
    endproperty
    a_delta: assert property (p_delta) else $error("delta decision wrong"); // R13

    property p_last_update;
        push |=> (last_r[$past(sample_chan_in)] == $past(word)) ##[1:6] pdo_valid_out;
    endproperty
    a_last_update: assert property (p_last_update) else $error("last value or send lost"); // R16

    c_push:      cover property (push);
    c_stall:     cover property (sample_valid_in && !sample_ready_out);
    c_pair:      cover property (pdo_valid_out && pdo_ready_in && !pdo_last_out ##1 sent_pulse);
    c_read_flag: cover property (flags_read && (flags_r != FLAGS_RESET));

endmodule

// *** hdl/analog_trigger_pkg.sv ***
// Constants shared by the analog input event trigger and its buffer.
// Assumes one system clock; object indices are those seen by the network master.
package analog_trigger_pkg;

    localparam int CHANNELS = 8;
    localparam int CHAN_W   = 3;
    localparam int RESULT_W = 10;
    localparam int WORD_W   = 16;
    localparam int LIMIT_W  = 32;
    localparam int DELTA_W  = 16;
    localparam int PAD_W    = 5;
    localparam int ENTRY_W  = CHAN_W + WORD_W;
    localparam int BUF_DEPTH = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Object dictionary indices
    localparam logic [15:0] IDX_TRIGGER_SELECT  = 16'h6421;
    localparam logic [15:0] IDX_SOURCE_FLAGS    = 16'h6422;
    localparam logic [15:0] IDX_GLOBAL_ENABLE   = 16'h6423;
    localparam logic [15:0] IDX_UPPER_THRESHOLD = 16'h6424;
    localparam logic [15:0] IDX_LOWER_THRESHOLD = 16'h6425;
    localparam logic [15:0] IDX_CHANGE_THRESH   = 16'h6426;

    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FIRST = 8'h01;
    localparam logic [7:0] SUB_LAST  = 8'h08;
    localparam logic [7:0] SUB_FLAGS = 8'h01;
    localparam logic [7:0] SUB_GLOBAL = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and values after reset
    localparam int SEL_UPPER_BIT = 0;
    localparam int SEL_LOWER_BIT = 1;
    localparam int SEL_DELTA_BIT = 2;
    localparam int ENABLE_BIT    = 0;

    localparam logic [7:0]         SEL_MASK      = 8'h07;
    localparam logic [7:0]         SEL_RESET     = 8'h04;
    localparam logic [7:0]         ENABLE_RESET  = 8'h00;
    localparam logic [LIMIT_W-1:0] LIMIT_RESET   = 32'h0000_0000;
    localparam logic [DELTA_W-1:0] DELTA_RESET   = 16'h00a0;
    localparam logic [WORD_W-1:0]  LAST_RESET    = 16'h0000;
    localparam logic [7:0]         FLAGS_RESET   = 8'h00;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_LOW,
        SER_HIGH
    } ser_state_t;

endpackage

// *** hdl/pdo_word_buffer.sv ***
// Two-entry buffer between trigger evaluation and the byte serializer.
// Assumes the writer honours in_ready_out and the reader honours out_valid_out.
`timescale 1ns/1ps

module pdo_word_buffer
    import analog_trigger_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               rst_b_in,
    input  wire logic               in_valid_in,
    input  wire logic [ENTRY_W-1:0] in_data_in,
    output logic                    in_ready_out,
    output logic                    out_valid_out,
    output logic      [ENTRY_W-1:0] out_data_out,
    input  wire logic               out_ready_in
);

    logic [ENTRY_W-1:0] mem_r [BUF_DEPTH];
    logic               wptr_r;
    logic               rptr_r;
    logic [1:0]         count_r;
    logic               push;
    logic               pop;
    logic [1:0]         count_nxt;

    assign push      = in_valid_in && in_ready_out;
    assign pop       = out_valid_out && out_ready_in;
    assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};
    assign out_data_out = mem_r[rptr_r];

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            wptr_r   <= 1'b0;
        end
        else if (push)
        begin
            mem_r[wptr_r] <= in_data_in;
            wptr_r        <= ~wptr_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rptr_r        <= 1'b0;
            count_r       <= 2'h0;
            in_ready_out  <= 1'b0;
            out_valid_out <= 1'b0;
        end
        else
        begin
            if (pop)
                rptr_r <= ~rptr_r;
            count_r       <= count_nxt;
            // Ready held low during reset so no word is taken before release
            in_ready_out  <= (count_nxt != 2'h2);
            out_valid_out <= (count_nxt != 2'h0);
        end
    end

endmodule

// *** sim/pdo_sink.sv ***
// Network-side receiver model: rebuilds analog words from the byte stream.
// Assumes the block offers bytes with valid held until ready is seen high.
`timescale 1ns/1ps

module pdo_sink (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       stall_in,
    input  wire logic       slow_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] byte_in,
    input  wire logic [2:0] chan_in,
    input  wire logic       last_in,
    output logic            ready_out,
    output logic            word_valid_out,
    output logic [15:0]     word_out,
    output logic [2:0]      word_chan_out
);
    logic       phase_r;
    logic [7:0] low_r;

    // Slow mode accepts every other cycle only
    assign ready_out = !stall_in && (!slow_in || phase_r);

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            phase_r <= 1'b0;
            low_r <= 8'h00;
            word_valid_out <= 1'b0;
            word_out <= 16'h0000;
            word_chan_out <= 3'h0;
        end
        else
        begin
            phase_r <= !phase_r;
            word_valid_out <= valid_in && ready_out && last_in;
            if (valid_in && ready_out && !last_in)
                low_r <= byte_in;
            if (valid_in && ready_out && last_in)
            begin
                word_out <= {byte_in, low_r};
                word_chan_out <= chan_in;
            end
        end
    end
endmodule

// *** sim/tb_top.sv ***
// Bench for the analog input event trigger: object port, samples, bytes.
// Assumes pdo_sink stands on the network side of the byte stream.
`timescale 1ns/1ps

module tb_top
    import analog_trigger_pkg::*;
;
    typedef struct {logic [2:0] ch; logic [9:0] res; logic sg; logic snd; logic [15:0] w;} row_t;

    logic        clk_in, rst_b_in, sv, ss, sready, wr, rd, done, err;
    logic        pv, pl, pready, stall, slow, wv;
    logic [2:0]  sc, pch, wch;
    logic [9:0]  sr;
    logic [15:0] idx, word;
    logic [7:0]  sub, pb;
    logic [31:0] wd, rdata;
    int          n_mismatch, samples_checked;
    row_t        rows [15];

    analog_input_event_trigger dut (.sample_valid_in(sv), .sample_chan_in(sc),
        .sample_result_in(sr), .sample_sign_in(ss), .sample_ready_out(sready),
        .sdo_write_in(wr), .sdo_read_in(rd), .sdo_index_in(idx), .sdo_subindex_in(sub),
        .sdo_wdata_in(wd), .sdo_rdata_out(rdata), .sdo_done_out(done), .sdo_error_out(err),
        .pdo_valid_out(pv), .pdo_byte_out(pb), .pdo_channel_out(pch), .pdo_last_out(pl),
        .pdo_ready_in(pready), .clk_in(clk_in), .rst_b_in(rst_b_in));

    pdo_sink sink (.clk_in(clk_in), .rst_b_in(rst_b_in), .stall_in(stall), .slow_in(slow),
        .valid_in(pv), .byte_in(pb), .chan_in(pch), .last_in(pl), .ready_out(pready),
        .word_valid_out(wv), .word_out(word), .word_chan_out(wch));

    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Strobe one cycle; done lands at the next edge and is seen at the negedge
    task automatic sdo(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [31:0] d, input logic [31:0] exp, input logic e);
        @(negedge clk_in);
        {wr, rd, idx, sub, wd} = {w, !w, i, s, d};
        @(negedge clk_in);
        {wr, rd} = 2'b00;
        cmp({31'h0, done}, 32'h1);
        cmp({31'h0, err}, {31'h0, e});
        if (!w)
            cmp(rdata, exp);
    endtask

    task automatic sample(input logic [2:0] c, input logic [9:0] r, input logic g);
        @(negedge clk_in);
        {sv, sc, sr, ss} = {1'b1, c, r, g};
        for (int i = 0; i <= 60 && sready !== 1'b1; i++)
        begin
            if (i == 60)
            begin
                n_mismatch++;
                complete_run();
            end
            @(negedge clk_in);
        end
        @(negedge clk_in);
        sv = 1'b0;
    endtask

    // Waits for a whole word at the receiver, or checks that none comes
    task automatic expect_word(input logic snd, input logic [2:0] c, input logic [15:0] w);
        int i;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk_in);
            #1;
            if (wv === 1'b1)
                break;
        end
        if (snd && i == 40)
        begin
            n_mismatch++;
            complete_run();
        end
        cmp({31'h0, wv === 1'b1}, {31'h0, snd});
        if (snd)
            cmp({13'h0, wch, word}, {13'h0, c, w});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {sv, sc, sr, ss, wr, rd, idx, sub, wd} = '0;
        {n_mismatch, samples_checked, stall} = '0;
        slow = 1'b1;
        rows = '{'{0, 10'h005, 0, 0, 0}, '{0, 10'h006, 0, 1, 16'h00c0},
                 '{0, 10'h00b, 0, 0, 0}, '{0, 10'h00c, 0, 1, 16'h0180},
                 '{0, 10'h001, 0, 1, 16'h0020}, '{1, 10'h3ff, 0, 1, 16'h7fe0},
                 '{2, 10'h100, 0, 0, 0}, '{2, 10'h101, 0, 1, 16'h2020},
                 '{2, 10'h101, 0, 1, 16'h2020}, '{3, 10'h3ff, 1, 1, 16'hffe0},
                 '{4, 10'h100, 0, 0, 0}, '{4, 10'h300, 0, 1, 16'h6000},
                 '{5, 10'h101, 0, 1, 16'h2020}, '{5, 10'h102, 0, 0, 0},
                 '{5, 10'h080, 0, 0, 0}};
        rst_b_in = 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_b_in = 1'b1;
        sdo(0, IDX_TRIGGER_SELECT, 8'h03, 0, 32'h04, 0);
        sdo(0, IDX_GLOBAL_ENABLE, SUB_GLOBAL, 0, 32'h0, 0);
        sdo(0, IDX_UPPER_THRESHOLD, 8'h08, 0, 32'h0, 0);
        sdo(0, IDX_LOWER_THRESHOLD, 8'h01, 0, 32'h0, 0);
        sdo(0, IDX_CHANGE_THRESH, 8'h02, 0, 32'ha0, 0);
        sdo(0, 16'h6427, 8'h01, 0, 32'h0, 1);
        sdo(1, IDX_SOURCE_FLAGS, SUB_FLAGS, 32'hff, 0, 1);
        sdo(1, IDX_TRIGGER_SELECT, 8'h08, 32'hff, 0, 0);
        sdo(0, IDX_TRIGGER_SELECT, 8'h08, 0, 32'h07, 0);
        // Disabled: a large change must stay silent
        sample(0, 10'h100, 0);
        expect_word(0, 0, 0);
        sdo(0, IDX_SOURCE_FLAGS, SUB_FLAGS, 0, 32'h0, 0);
        sdo(1, IDX_GLOBAL_ENABLE, SUB_GLOBAL, 32'h1, 0, 0);
        sdo(1, IDX_TRIGGER_SELECT, 8'h03, 32'h01, 0, 0);
        sdo(1, IDX_UPPER_THRESHOLD, 8'h03, 32'h2000_0000, 0, 0);
        sdo(1, IDX_TRIGGER_SELECT, 8'h04, 32'h02, 0, 0);
        sdo(1, IDX_TRIGGER_SELECT, 8'h05, 32'h03, 0, 0);
        sdo(1, IDX_UPPER_THRESHOLD, 8'h05, 32'h4000_0000, 0, 0);
        sdo(1, IDX_LOWER_THRESHOLD, 8'h05, 32'h1000_0000, 0, 0);
        sdo(1, IDX_TRIGGER_SELECT, 8'h06, 32'h05, 0, 0);
        sdo(1, IDX_UPPER_THRESHOLD, 8'h06, 32'h2000_0000, 0, 0);
        foreach (rows[k])
        begin
            sample(rows[k].ch, rows[k].res, rows[k].sg);
            expect_word(rows[k].snd, rows[k].ch, rows[k].w);
            if (rows[k].snd)
                sdo(0, IDX_SOURCE_FLAGS, SUB_FLAGS, 0, 32'h0, 0);
        end
        // Receiver stalls: three words must wait and arrive in order
        stall = 1'b1;
        sample(6, 10'h010, 0);
        sample(6, 10'h020, 0);
        sample(6, 10'h030, 0);
        repeat (2) @(negedge clk_in);
        cmp({31'h0, sready}, 32'h0);
        sdo(0, IDX_SOURCE_FLAGS, SUB_FLAGS, 0, 32'h40, 0);
        sdo(0, IDX_SOURCE_FLAGS, SUB_FLAGS, 0, 32'h00, 0);
        {stall, slow} = 2'b00;
        expect_word(1, 6, 16'h0200);
        expect_word(1, 6, 16'h0400);
        expect_word(1, 6, 16'h0600);
        // Reset in mid-run restores the defaults
        @(negedge clk_in);
        rst_b_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rst_b_in = 1'b1;
        sdo(0, IDX_GLOBAL_ENABLE, SUB_GLOBAL, 0, 32'h0, 0);
        sdo(0, IDX_TRIGGER_SELECT, 8'h03, 0, 32'h04, 0);
        sdo(0, IDX_UPPER_THRESHOLD, 8'h03, 0, 32'h0, 0);
        complete_run();
    end
endmodule
